// ### logic/relay_alarm_defs.svh
// constants for the visibility alarm relay block
`ifndef RELAY_ALARM_DEFS_SVH
`define RELAY_ALARM_DEFS_SVH

// register byte offsets
`define OFS_THRESH1 8'h00
`define OFS_THRESH2 8'h04
`define OFS_THRESH3 8'h08
`define OFS_ON_DELAY 8'h0c
`define OFS_OFF_DELAY 8'h10
`define OFS_CONTROL 8'h14
`define OFS_OVERRIDE 8'h18
`define OFS_STATUS 8'h1c
`define OFS_MASK 8'h20
`define OFS_STATE 8'h24
`define OFS_VISIBILITY 8'h28

// field positions
`define CTRL_HW_SEL_BIT 0
`define OVR_ESCAPE_BIT 3
`define STATE_HW_BIT 3

// reset values
`define THRESH_RESET 16'h0000
`define DELAY_RESET 8'h05
`define CONTROL_RESET 1'b0

// timing
`define CLK_HZ 64'd200000000
`define MINUTE_S 64'd60
`define MINUTE_CYCLES (`MINUTE_S * `CLK_HZ)

`endif

// ### logic/relay_alarm_pkg.sv
// types for the visibility alarm relay block
package relay_alarm_pkg;

	// per-output relay control state
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ARMING = 2'b01,
		ST_ON = 2'b10,
		ST_RELEASING = 2'b11
	} relay_state_t;

	typedef logic [15:0] vis_t;
	typedef logic [7:0] minutes_t;

endpackage

// ### logic/visibility_alarm_relay_control.sv
// three alarm relay controls driven by visibility limits or hardware status
//
// Contract
// - three independent open-collector alarm outputs decided by threshold logic
// - thresholds compare against the ten-minute average visibility only
// - a zero threshold disables its comparison; output never set by visibility
// - threshold n governs only output n; below asserts, above releases
// - condition change must persist on/off delay minutes; both default five; the free-running tick makes it n-1 to n minutes
// - third output selectable: threshold three or hardware diagnostic status
// - on hardware selection, third output follows any hardware alarm
// - after reset all three thresholds hold zero
// - override forces one or all outputs on until escape
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "relay_alarm_defs.svh"

module visibility_alarm_relay_control
	import relay_alarm_pkg::*;
#(
	parameter logic [35:0] MINUTE_CYCLES = 36'(`MINUTE_CYCLES)
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// measurement and diagnostics
	input wire logic [15:0] vis_avg10,
	input wire logic hw_alarm,
	// open-collector drives, 1 = transistor pulls
	output logic [2:0] relay_pull,
	output logic irq
);

	// register map, one 32-bit word per offset, narrow fields in the low bits:
	//   thresholds one to three, then assert delay and release delay in minutes,
	//   control (bit 0 hands output three to the hardware alarm),
	//   override (bits 2:0 force on and accumulate, bit 3 escapes and wins),
	//   status (bits 2:0 switched on, 5:3 switched off, cleared by its read),
	//   mask of the same layout, state (drive and hardware alarm), visibility.
	// the control and override words have no read side effects, so software may
	// poll them freely; only the status read is destructive.

	// register storage
	vis_t thresh_q [3];
	minutes_t on_delay_q;
	minutes_t off_delay_q;
	logic hw_sel_q;
	logic [2:0] force_q;
	logic [5:0] status_q;
	logic [5:0] mask_q;
	logic [31:0] rdata_q;

	// minute timebase
	logic [35:0] tick_cnt_q;
	logic minute_tick;

	// per-output state
	relay_state_t st_q [3];
	minutes_t wait_q [3];
	logic [2:0] vis_on;
	logic [2:0] cond;
	logic [2:0] rise;
	logic [2:0] fall;

	// register write decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// the drive is held through a pending release, so releasing counts as on
	function automatic logic relay_active(input relay_state_t s);
		relay_active = (s == ST_ON) || (s == ST_RELEASING);
	endfunction

	// a delay of n minutes expires on the n-th tick seen since the change
	function automatic logic delay_done(input minutes_t w, input minutes_t d);
		delay_done = (w + 8'h1) >= d;
	endfunction

	// read mux; unmapped offsets and the upper bits of narrow fields read zero
	function automatic logic [31:0] read_word(input logic [7:0] a);
		case (a)
			`OFS_THRESH1: read_word = {16'h0, thresh_q[0]};
			`OFS_THRESH2: read_word = {16'h0, thresh_q[1]};
			`OFS_THRESH3: read_word = {16'h0, thresh_q[2]};
			`OFS_ON_DELAY: read_word = {24'h0, on_delay_q};
			`OFS_OFF_DELAY: read_word = {24'h0, off_delay_q};
			`OFS_CONTROL: read_word = {31'h0, hw_sel_q};
			`OFS_OVERRIDE: read_word = {29'h0, force_q};
			`OFS_STATUS: read_word = {26'h0, status_q};
			`OFS_MASK: read_word = {26'h0, mask_q};
			`OFS_STATE: read_word = {28'h0, hw_alarm, relay_pull};
			`OFS_VISIBILITY: read_word = {16'h0, vis_avg10};
			default: read_word = 32'h0;
		endcase
	endfunction

	// minute tick from the system clock; long count so a sim can shorten it.
	// the counter runs free from reset, so the first minute after a condition
	// change is partial: a delay of n minutes really lasts n-1 to n minutes.
	// a per-output prescaler would be exact but costs three wide counters.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_q <= 36'h0;
		end else if (tick_cnt_q >= MINUTE_CYCLES - 36'h1) begin
			tick_cnt_q <= 36'h0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 36'h1;
		end
	end

	assign minute_tick = (tick_cnt_q >= MINUTE_CYCLES - 36'h1);

	// thresholds, cleared by reset so nothing alarms until programmed
	// thresholds reset zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			thresh_q[0] <= `THRESH_RESET;
			thresh_q[1] <= `THRESH_RESET;
			thresh_q[2] <= `THRESH_RESET;
		end else if (wr) begin
			if (hit(addr, `OFS_THRESH1)) begin
				thresh_q[0] <= wdata[15:0];
			end
			if (hit(addr, `OFS_THRESH2)) begin
				thresh_q[1] <= wdata[15:0];
			end
			if (hit(addr, `OFS_THRESH3)) begin
				thresh_q[2] <= wdata[15:0];
			end
		end
	end

	// assert and release delays in minutes
	// default delays five
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			on_delay_q <= `DELAY_RESET;
			off_delay_q <= `DELAY_RESET;
		end else if (wr) begin
			if (hit(addr, `OFS_ON_DELAY)) begin
				on_delay_q <= wdata[7:0];
			end
			if (hit(addr, `OFS_OFF_DELAY)) begin
				off_delay_q <= wdata[7:0];
			end
		end
	end

	// source select for the third output
	// third output source
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hw_sel_q <= `CONTROL_RESET;
		end else if (wr && hit(addr, `OFS_CONTROL)) begin
			hw_sel_q <= wdata[`CTRL_HW_SEL_BIT];
		end
	end

	// operator override: set bits accumulate, escape clears them all;
	// forcing sits on top of the delay machines, which keep running underneath,
	// so after an escape the drive falls straight back to the settled condition
	// force until escape
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			force_q <= 3'h0;
		end else if (wr && hit(addr, `OFS_OVERRIDE)) begin
			if (wdata[`OVR_ESCAPE_BIT]) begin
				force_q <= 3'h0;
			end else begin
				force_q <= force_q | wdata[2:0];
			end
		end
	end

	// interrupt mask
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_q <= 6'h0;
		end else if (wr && hit(addr, `OFS_MASK)) begin
			mask_q <= wdata[5:0];
		end
	end

	// per-output condition and delay machine:
	//   off        condition false, drive released, timer held at zero
	//   arming     condition true, counting minute ticks toward the assert delay
	//   on         condition true, drive pulling, timer held at zero
	//   releasing  condition false, drive still pulling, counting the release delay
	// a zero delay skips the counting state, so the drive follows within two cycles
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_out
			assign vis_on[g] = (thresh_q[g] != 16'h0) && (vis_avg10 < thresh_q[g]);

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					st_q[g] <= ST_OFF;
					wait_q[g] <= 8'h0;
				end else begin
					case (st_q[g])
						ST_OFF: begin
							wait_q[g] <= 8'h0;
							if (vis_on[g]) begin
								st_q[g] <= (on_delay_q == 8'h0) ? ST_ON : ST_ARMING;
							end
						end
						ST_ARMING: begin
							if (!vis_on[g]) begin
								st_q[g] <= ST_OFF;
								wait_q[g] <= 8'h0;
							end else if (minute_tick) begin
								if (delay_done(wait_q[g], on_delay_q)) begin
									st_q[g] <= ST_ON;
									wait_q[g] <= 8'h0;
								end else begin
									wait_q[g] <= wait_q[g] + 8'h1;
								end
							end
						end
						ST_ON: begin
							wait_q[g] <= 8'h0;
							if (!vis_on[g]) begin
								st_q[g] <= (off_delay_q == 8'h0) ? ST_OFF : ST_RELEASING;
							end
						end
						ST_RELEASING: begin
							if (vis_on[g]) begin
								st_q[g] <= ST_ON;
								wait_q[g] <= 8'h0;
							end else if (minute_tick) begin
								if (delay_done(wait_q[g], off_delay_q)) begin
									st_q[g] <= ST_OFF;
									wait_q[g] <= 8'h0;
								end else begin
									wait_q[g] <= wait_q[g] + 8'h1;
								end
							end
						end
						default: begin
							st_q[g] <= ST_OFF;
							wait_q[g] <= 8'h0;
						end
					endcase
				end
			end
		end
	endgenerate

	// condition before override; hardware path bypasses the minute delays
	// hardware alarm follows
	always_comb begin
		cond[0] = relay_active(st_q[0]);
		cond[1] = relay_active(st_q[1]);
		if (hw_sel_q) begin
			cond[2] = hw_alarm;
		end else begin
			cond[2] = relay_active(st_q[2]);
		end
	end

	// registered pin drive, override on top
	// forced outputs on
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			relay_pull <= 3'h0;
		end else begin
			relay_pull <= cond | force_q;
		end
	end

	// edges of the output drive feed the event flags
	assign rise = (cond | force_q) & ~relay_pull;
	assign fall = ~(cond | force_q) & relay_pull;

	// sticky events: [2:0] output on, [5:3] output off; set beats read clear,
	// so an edge landing in the cycle of the status read is never lost; it
	// shows up again on the next read instead
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_q <= 6'h0;
		end else if (rd && hit(addr, `OFS_STATUS)) begin
			status_q <= {fall, rise};
		end else begin
			status_q <= status_q | {fall, rise};
		end
	end

	// level interrupt from unmasked flags; combinational from registers only,
	// so it cannot glitch on the bus inputs
	assign irq = |(status_q & mask_q);

	// read data, valid the cycle after the strobe only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 32'h0;
		end else if (rd) begin
			rdata_q <= read_word(addr);
		end else begin
			// zero between reads lets a wired-or bus share the return path
			rdata_q <= 32'h0;
		end
	end

	assign rdata = rdata_q;

endmodule

`default_nettype wire

// ### bench/relay_coils.sv
// open-collector relay coil model at the alarm outputs
`timescale 1ns/1ps
`default_nettype none
module relay_coils (
	// drive from the alarm block
	input wire logic [2:0] pull,
	// coil state seen by the field wiring
	output logic [2:0] coil_on
);
	// one coil each
	// a pulling transistor energises its coil; released, it sits off
	assign coil_on = pull;
endmodule
`default_nettype wire

// ### bench/relay_alarm_asserts.sv
// port checker for the alarm relay block
`timescale 1ns/1ps
`default_nettype none
`include "relay_alarm_defs.svh"
module relay_checker (
	// clock, reset and register port
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	// measurement, diagnostics and outputs
	input wire logic [15:0] vis_avg10,
	input wire logic hw_alarm,
	input wire logic [2:0] relay_pull,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic hw_q;
	// mirror of the output three mode, since control is not visible
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			hw_q <= 1'b0;
		else if (wr && addr == `OFS_CONTROL)
			hw_q <= wdata[`CTRL_HW_SEL_BIT];
	end
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data not zero");
	unmapped_read_a: assert property (rd && addr == 8'h30 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	state_read_a: assert property (rd && addr == `OFS_STATE |=>
		rdata == {28'h0, $past(hw_alarm), $past(relay_pull)}) else $error("bad state");
	vis_read_a: assert property (rd && addr == `OFS_VISIBILITY |=>
		rdata == {16'h0, $past(vis_avg10)}) else $error("bad visibility");
	limit_back_a: assert property (wr && addr == `OFS_THRESH3 ##1 rd && addr == `OFS_THRESH3
		|=> rdata == {16'h0, $past(wdata[15:0], 2)}) else $error("bad limit");
	force_all_a: assert property (wr && addr == `OFS_OVERRIDE && wdata[3:0] == 4'h7
		|-> ##[1:2] relay_pull == 3'h7) else $error("force missed");
	hw_follow_a: assert property (hw_q && $past(hw_q) && hw_alarm
		|-> ##[1:2] relay_pull[2]) else $error("hw alarm missed");
	irq_fall_a: assert property ($fell(irq) |->
		$past(rd && addr == `OFS_STATUS || wr && addr == `OFS_MASK)) else $error("irq fell");
	irq_rise_a: assert property ($rose(irq) |->
		$changed(relay_pull) || $past(wr && addr == `OFS_MASK)) else $error("irq rose");
endmodule
bind visibility_alarm_relay_control relay_checker i_chk (.clk(clk), .resetn(resetn),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vis_avg10(vis_avg10),
	.hw_alarm(hw_alarm), .relay_pull(relay_pull), .irq(irq));
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the alarm relay block
`timescale 1ns/1ps
`default_nettype none
`include "relay_alarm_defs.svh"
module tb_top import relay_alarm_pkg::*;;
	localparam int M = 4;
	localparam int LO = 4 * M - 1;
	localparam int HI = 5 * M + 4;
	typedef struct packed {vis_t v; logic [2:0] e;} row_t;
	row_t rows [4] = '{'{16'h0320, 3'h1}, '{16'h01f4, 3'h3}, '{16'h00c8, 3'h7}, '{16'h03e8, 3'h0}};
	logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, hw_alarm = 1'b0, irq;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata;
	vis_t vis = 16'h04b0;
	logic [2:0] relay_pull, coil_on;
	int fail_count = 0, n_checks = 0;
	// short minute keeps the five minute delays to about twenty cycles
	visibility_alarm_relay_control #(.MINUTE_CYCLES(36'(M))) i_dut (.clk(clk),
		.resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.vis_avg10(vis), .hw_alarm(hw_alarm), .relay_pull(relay_pull), .irq(irq));
	relay_coils i_coils (.pull(relay_pull), .coil_on(coil_on));
	initial forever #2.5 clk = ~clk;
	// one bus cycle, driven on an edge; returns on the sampling edge, where
	// the design's outputs still show what they held before that edge
	task acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask
	task idle(input int n);
		repeat (n) acc(1'b0, 1'b0, 8'h0, 32'h0);
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// waits for a coil pattern; the count must land inside the window
	task wait_pull(input logic [2:0] e, input int lo, input int hi);
		int k;
		k = 0;
		while (coil_on !== e && k <= hi) begin
			idle(1);
			k++;
		end
		chk({31'h0, k < lo || k > hi}, 32'h0);
		if (k > hi) end_sim();
	endtask
	task end_sim();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		acc(1'b1, 1'b0, `OFS_THRESH1, 32'h3e8);
		acc(1'b1, 1'b0, `OFS_THRESH2, 32'h258);
		acc(1'b1, 1'b0, `OFS_THRESH3, 32'h12c);
		acc(1'b0, 1'b1, `OFS_THRESH3, 32'h0);
		idle(1);
		chk(rdata, 32'h12c);
		acc(1'b0, 1'b1, `OFS_VISIBILITY, 32'h0);
		idle(1);
		chk(rdata, 32'h4b0);
		// level rows; the last equals limit one, which is not below
		foreach (rows[i]) begin
			vis <= rows[i].v;
			wait_pull(rows[i].e, LO, HI);
		end
		// a short dip below limit one must not count toward the next
		vis <= 16'h0320;
		idle(8);
		vis <= 16'h04b0;
		idle(8);
		vis <= 16'h0320;
		wait_pull(3'h1, LO, HI);
		// output three on hardware status ignores limit three
		acc(1'b1, 1'b0, `OFS_CONTROL, 32'h1);
		vis <= 16'h00c8;
		wait_pull(3'h3, LO, HI);
		hw_alarm <= 1'b1;
		wait_pull(3'h7, 1, 2);
		hw_alarm <= 1'b0;
		wait_pull(3'h3, 1, 2);
		// force all, escape with every bit set, then force one
		acc(1'b1, 1'b0, `OFS_OVERRIDE, 32'h7);
		wait_pull(3'h7, 1, 2);
		acc(1'b1, 1'b0, `OFS_OVERRIDE, 32'hf);
		wait_pull(3'h3, 1, 2);
		acc(1'b1, 1'b0, `OFS_OVERRIDE, 32'h4);
		wait_pull(3'h7, 1, 2);
		// mid-run reset, then defaults, unmapped read and zero limits
		resetn <= 1'b0;
		idle(2);
		resetn <= 1'b1;
		chk({29'h0, relay_pull}, 32'h0);
		for (int i = 0; i < 5; i++) begin
			acc(1'b0, 1'b1, 8'(4 * i), 32'h0);
			idle(1);
			chk(rdata, i < 3 ? 32'h0 : 32'h5);
		end
		acc(1'b0, 1'b1, 8'h30, 32'h0);
		idle(1);
		chk(rdata, 32'h0);
		idle(HI);
		chk({29'h0, relay_pull}, 32'h0);
		// interrupt masked, unmasked, then cleared by the status read
		acc(1'b1, 1'b0, `OFS_THRESH1, 32'h3e8);
		wait_pull(3'h1, LO, HI);
		chk({31'h0, irq}, 32'h0);
		acc(1'b1, 1'b0, `OFS_MASK, 32'h1);
		idle(1);
		chk({31'h0, irq}, 32'h1);
		acc(1'b0, 1'b1, `OFS_STATUS, 32'h0);
		idle(1);
		chk(rdata, 32'h1);
		chk({31'h0, irq}, 32'h0);
		acc(1'b0, 1'b1, `OFS_STATE, 32'h0);
		idle(1);
		chk(rdata, 32'h1);
		end_sim();
	end
endmodule
`default_nettype wire
